// [rtl/mic_input_bias_config_regs.sv]
// microphone bias, power-down and input routing register bank
// assumes a two-wire bus host on scl/sda and analog controls on the outputs
`default_nettype none
`include "mic_cfg_map.svh"

module mic_input_bias_config_regs
  import mic_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEF
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       headset_det_en,
  input  wire logic       headset_present,
  input  wire logic       bypass_left_plus,
  input  wire logic       bypass_right_plus,
  input  wire logic       gain_settled,
  output logic            soft_power_down,
  output logic [1:0]      mic_bias_supply,
  output logic [1:0]      left_plus_route,
  output logic [1:0]      right_plus_route,
  output logic [1:0]      left_minus_p_route,
  output logic [1:0]      common_mode_route,
  output logic [1:0]      left_minus_m_route,
  output logic            left_plus_tie_cm,
  output logic            right_plus_tie_cm,
  output logic            left_minus_tie_cm
);

  logic       scl_f;
  logic       sda_f;
  logic       scl_prev_q;
  logic       sda_prev_q;
  bus_state_t st_q;
  logic [3:0] cnt_q;
  byte_t      sh_q;
  byte_t      rd_sh_q;
  byte_t      ptr_q;
  byte_t      page_q;
  byte_t      bias_q;
  byte_t      pos_q;
  byte_t      neg_q;
  byte_t      cmt_q;
  logic       rw_q;
  logic       nack_q;
  logic       oe_q;

  pin_sync3 u_scl_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (scl),
    .dout    (scl_f)
  );

  pin_sync3 u_sda_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (sda_i),
    .dout    (sda_f)
  );

  // bus edge and condition decode
  wire scl_rise  = scl_f & ~scl_prev_q;
  wire scl_fall  = ~scl_f & scl_prev_q;
  wire bus_start = ~sda_f & sda_prev_q & scl_f & scl_prev_q;
  wire bus_stop  = sda_f & ~sda_prev_q & scl_f & scl_prev_q;
  wire byte_done = scl_fall & (cnt_q == `BIT_COUNT);
  wire addr_hit  = (sh_q[7:1] == DEV_ADDR);

  // register decode
  wire page1   = (page_q == `CFG_PAGE);
  wire wr_stb  = (st_q == ST_WDATA) & byte_done;
  wire hit_pg  = (ptr_q == `PAGE_CTRL_OFS);
  wire hit_bia = page1 & (ptr_q == `BIAS_OFS);
  wire hit_pos = page1 & (ptr_q == `POS_OFS);
  wire hit_neg = page1 & (ptr_q == `NEG_OFS);
  wire hit_cmt = page1 & (ptr_q == `CMT_OFS);

  // live status folded into the read path, never stored
  wire byte_t cmt_rd = {cmt_q[7:1], gain_settled};

  // reserved slot and unmapped offsets read as zero
  wire byte_t rd_byte = hit_pg  ? page_q :
                        hit_bia ? bias_q :
                        hit_pos ? pos_q  :
                        hit_neg ? neg_q  :
                        hit_cmt ? cmt_rd : `REG_RST;

  // load of the next read byte
  wire rd_load = ((st_q == ST_AACK) & scl_fall & rw_q) |
                 ((st_q == ST_RDACK) & scl_fall & ~nack_q);

  // analog control decode
  wire [1:0] bias_field = bias_q[1:0];
  wire bias_allow = bias_q[`HS_FORCE_BIT] | ~headset_det_en | headset_present;
  wire [1:0] bias_sel_d = bias_allow ? bias_field : 2'b00;
  wire lp_used = (pos_q[7:6] != 2'b00) | bypass_left_plus;
  wire rp_used = (pos_q[5:4] != 2'b00) | bypass_right_plus;
  wire lm_used = (pos_q[3:2] != 2'b00) | (neg_q[5:4] != 2'b00);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  // bus protocol engine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      rd_sh_q <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      nack_q  <= 1'b1;
      oe_q    <= 1'b0;
    end else if (bus_start) begin
      st_q  <= ST_ADDR;
      cnt_q <= 4'h0;
      oe_q  <= 1'b0;
    end else if (bus_stop) begin
      st_q <= ST_IDLE;
      oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == ST_RDACK) begin
        nack_q <= sda_f;
      end else if (st_q inside {ST_ADDR, ST_REG, ST_WDATA, ST_RDATA}) begin
        sh_q  <= {sh_q[6:0], sda_f};
        cnt_q <= cnt_q + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (st_q)
        ST_IDLE: begin
          oe_q <= 1'b0;
        end
        ST_ADDR: begin
          if (cnt_q == `BIT_COUNT) begin
            st_q <= addr_hit ? ST_AACK : ST_IDLE;
            oe_q <= addr_hit;
            rw_q <= sh_q[0];
          end
        end
        ST_AACK, ST_RDACK: begin
          cnt_q <= 4'h0;
          if (rd_load) begin
            st_q    <= ST_RDATA;
            rd_sh_q <= rd_byte;
            oe_q    <= ~rd_byte[7];
            ptr_q   <= ptr_q + 8'h01;
          end else begin
            st_q <= (st_q == ST_AACK) ? ST_REG : ST_IDLE;
            oe_q <= 1'b0;
          end
        end
        ST_REG: begin
          if (cnt_q == `BIT_COUNT) begin
            ptr_q <= sh_q;
            st_q  <= ST_RGACK;
            oe_q  <= 1'b1;
          end
        end
        ST_RGACK, ST_WACK: begin
          cnt_q <= 4'h0;
          st_q  <= ST_WDATA;
          oe_q  <= 1'b0;
        end
        ST_WDATA: begin
          if (cnt_q == `BIT_COUNT) begin
            ptr_q <= ptr_q + 8'h01;
            st_q  <= ST_WACK;
            oe_q  <= 1'b1;
          end
        end
        ST_RDATA: begin
          if (cnt_q == `BIT_COUNT) begin
            st_q <= ST_RDACK;
            oe_q <= 1'b0;
          end else begin
            rd_sh_q <= {rd_sh_q[6:0], 1'b0};
            oe_q    <= ~rd_sh_q[6];
          end
        end
        default: begin
          st_q <= ST_IDLE;
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // register file; offset 0x2d and unmapped offsets take no write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      page_q <= `REG_RST;
      bias_q <= `REG_RST;
      pos_q  <= `REG_RST;
      neg_q  <= `REG_RST;
      cmt_q  <= `REG_RST;
    end else if (wr_stb) begin
      if (hit_pg) begin
        page_q <= sh_q;
      end
      if (hit_bia) begin
        bias_q <= sh_q & `BIAS_WMASK;
      end
      if (hit_pos) begin
        pos_q <= sh_q & `POS_WMASK;
      end
      if (hit_neg) begin
        neg_q <= sh_q & `NEG_WMASK;
      end
      if (hit_cmt) begin
        cmt_q <= sh_q & `CMT_WMASK;
      end
    end
  end

  // registered analog controls
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mic_bias_supply   <= 2'b00;
      left_plus_tie_cm  <= 1'b0;
      right_plus_tie_cm <= 1'b0;
      left_minus_tie_cm <= 1'b0;
    end else begin
      mic_bias_supply   <= bias_sel_d;
      left_plus_tie_cm  <= cmt_q[`LP_TIE_BIT] & ~lp_used;
      right_plus_tie_cm <= cmt_q[`RP_TIE_BIT] & ~rp_used;
      left_minus_tie_cm <= cmt_q[`LM_TIE_BIT] & ~lm_used;
    end
  end

  assign sda_o              = 1'b0;
  assign sda_oe             = oe_q;
  assign soft_power_down    = bias_q[`PD_BIT];
  assign left_plus_route    = pos_q[7:6];
  assign right_plus_route   = pos_q[5:4];
  assign left_minus_p_route = pos_q[3:2];
  assign common_mode_route  = neg_q[7:6];
  assign left_minus_m_route = neg_q[5:4];

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_wr_bias;
    wr_stb && hit_bia;
  endsequence

  sequence s_wr_pos;
    wr_stb && hit_pos;
  endsequence

  sequence s_wr_neg;
    wr_stb && hit_neg;
  endsequence

  sequence s_wr_cmt;
    wr_stb && hit_cmt;
  endsequence

  a_pd_write: assert property (
    s_wr_bias |=> soft_power_down == $past(sh_q[7]))
    else $error("power-down bit does not follow the write");

  a_bias_forced: assert property (
    s_wr_bias ##1 bias_q[`HS_FORCE_BIT] |=> mic_bias_supply == $past(sh_q[1:0], 2))
    else $error("forced bias level differs from written field");

  a_bias_gated: assert property (
    (!bias_q[`HS_FORCE_BIT] && headset_det_en && !headset_present) |=> mic_bias_supply == 2'b00)
    else $error("bias powered without headset while gated");

  a_pos_route: assert property (
    s_wr_pos |=> {left_plus_route, right_plus_route, left_minus_p_route} == $past(sh_q[7:2]))
    else $error("positive routing fields do not follow the write");

  a_cm_route: assert property (
    s_wr_neg |=> common_mode_route == $past(sh_q[7:6]))
    else $error("common-mode routing does not follow the write");

  a_lm_neg_route: assert property (
    s_wr_neg |=> left_minus_m_route == $past(sh_q[5:4]) && neg_q[3:0] == 4'h0)
    else $error("left-minus negative routing wrong after write");

  a_tie_plus: assert property (
    ##1 left_plus_tie_cm == $past(cmt_q[`LP_TIE_BIT] && !lp_used)
        && right_plus_tie_cm == $past(cmt_q[`RP_TIE_BIT] && !rp_used))
    else $error("plus input tie disagrees with use and setting");

  a_tie_minus: assert property (
    lm_used |=> !left_minus_tie_cm)
    else $error("left-minus tied while routed to the amplifier");

  a_status_read: assert property (
    (rd_load && hit_cmt) |=> rd_sh_q[0] == $past(gain_settled))
    else $error("gain-applied status not loaded into read byte");

  a_status_nowrite: assert property (
    s_wr_cmt |=> cmt_q[`GAIN_DONE_BIT] == 1'b0 [*2])
    else $error("write reached the read-only status bit");

endmodule : mic_input_bias_config_regs

`default_nettype wire

// [rtl/mic_cfg_map.svh]
// register map constants for the microphone front-end configuration bank
// assumes a paged 8-bit register space reached over a two-wire bus
`ifndef MIC_CFG_MAP_SVH
`define MIC_CFG_MAP_SVH

`define DEV_ADDR_DEF    7'h18
`define PAGE_CTRL_OFS   8'h00
`define CFG_PAGE        8'h01
`define RSVD_A_OFS      8'h2d
`define BIAS_OFS        8'h2e
`define POS_OFS         8'h30
`define NEG_OFS         8'h31
`define CMT_OFS         8'h32

`define BIAS_WMASK      8'h8b
`define POS_WMASK       8'hfc
`define NEG_WMASK       8'hf0
`define CMT_WMASK       8'he0
`define REG_RST         8'h00

`define PD_BIT          7
`define HS_FORCE_BIT    3
`define LP_TIE_BIT      7
`define RP_TIE_BIT      6
`define LM_TIE_BIT      5
`define GAIN_DONE_BIT   0
`define BIT_COUNT       4'd8

`endif

// [rtl/mic_cfg_pkg.sv]
// types shared by the microphone configuration bank
// assumes nothing beyond a SystemVerilog-2012 compiler
`default_nettype none

package mic_cfg_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_AACK  = 4'h2,
    ST_REG   = 4'h3,
    ST_RGACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WACK  = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDACK = 4'h8
  } bus_state_t;

endpackage : mic_cfg_pkg

`default_nettype wire

// [rtl/pin_sync3.sv]
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk_sys and idles high
`default_nettype none

module pin_sync3 (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // output follows only once second and third stage agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end

endmodule : pin_sync3

`default_nettype wire

// [verif/mic_host_model.sv]
// two-wire bus host model with bit, byte and register transfer tasks
// assumes clk_sys at 100 MHz and an open-drain data wire with a pull-up
`default_nettype none

module mic_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_o,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda_line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sda_q;

  // wire is low if either party pulls it, else the pull-up wins
  assign sda_line = sda_q & ~(sda_oe & ~sda_o);

  initial begin
    scl = 1'b1;
    sda_q = 1'b1;
  end

  // one scl phase of 10 clk_sys, above the 8 the bank needs
  task automatic half();
    repeat (10) @(negedge clk_sys);
  endtask : half

  task automatic start();
    sda_q = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_q = 1'b0;
    half();
    scl = 1'b0;
  endtask : start

  task automatic stop();
    half();
    sda_q = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_q = 1'b1;
    half();
  endtask : stop

  task automatic put(input logic b);
    half();
    sda_q = b;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
  endtask : put

  // data is taken at the end of the high phase
  task automatic get(output logic b);
    half();
    sda_q = 1'b1;
    half();
    scl = 1'b1;
    half();
    b = sda_line;
    scl = 1'b0;
  endtask : get

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put(d[i]);
    end
    get(a);
    ack = ~a;
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get(d[i]);
    end
    put(last);
  endtask : rbyte

  task automatic write(input logic [6:0] dev, input logic [7:0] ofs,
                       input logic [7:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start();
    wbyte({dev, 1'b0}, a0);
    wbyte(ofs, a1);
    wbyte(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask : write

  task automatic read(input logic [6:0] dev, input logic [7:0] ofs,
                      output logic [7:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start();
    wbyte({dev, 1'b0}, a0);
    wbyte(ofs, a1);
    start();
    wbyte({dev, 1'b1}, a2);
    rbyte(1'b1, d);
    stop();
    ack = a0 & a1 & a2;
  endtask : read
endmodule : mic_host_model

`default_nettype wire

// [verif/test_mic_input_bias_config_regs.sv]
// self-checking bench for the microphone bias and routing register bank
// assumes the host model on the bus pins and random side inputs
`default_nettype none
`include "mic_cfg_map.svh"

module test_mic_input_bias_config_regs
  import mic_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        rst_n;
  logic        scl;
  logic        sda_line;
  logic        sda_o;
  logic        sda_oe;
  logic        det;
  logic        pres;
  logic        byp_l;
  logic        byp_r;
  logic        settled;
  logic        pd;
  logic [1:0]  bias;
  logic [1:0]  lp_r;
  logic [1:0]  rp_r;
  logic [1:0]  lmp_r;
  logic [1:0]  cm_r;
  logic [1:0]  lmm_r;
  logic [2:0]  tie;
  logic [15:0] lfsr;
  logic        ack;
  byte_t       d;
  byte_t       sh [4];
  int          fail_count = 0;
  int          compares = 0;

  localparam byte_t OFS [4] = '{`BIAS_OFS, `POS_OFS, `NEG_OFS, `CMT_OFS};
  localparam byte_t MSK [4] = '{`BIAS_WMASK, `POS_WMASK, `NEG_WMASK, `CMT_WMASK};

  always #5 clk_sys = ~clk_sys;

  mic_input_bias_config_regs mic_input_bias_config_regs_i (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .scl                (scl),
    .sda_i              (sda_line),
    .sda_o              (sda_o),
    .sda_oe             (sda_oe),
    .headset_det_en     (det),
    .headset_present    (pres),
    .bypass_left_plus   (byp_l),
    .bypass_right_plus  (byp_r),
    .gain_settled       (settled),
    .soft_power_down    (pd),
    .mic_bias_supply    (bias),
    .left_plus_route    (lp_r),
    .right_plus_route   (rp_r),
    .left_minus_p_route (lmp_r),
    .common_mode_route  (cm_r),
    .left_minus_m_route (lmm_r),
    .left_plus_tie_cm   (tie[2]),
    .right_plus_tie_cm  (tie[1]),
    .left_minus_tie_cm  (tie[0])
  );

  mic_host_model mic_host_model_i (
    .clk_sys  (clk_sys),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .scl      (scl),
    .sda_line (sda_line)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [1:0] ebias();
    return (sh[0][3] | ~det | pres) ? sh[0][1:0] : 2'h0;
  endfunction : ebias

  function automatic logic [2:0] etie();
    etie[2] = sh[3][7] & ~((|sh[1][7:6]) | byp_l);
    etie[1] = sh[3][6] & ~((|sh[1][5:4]) | byp_r);
    etie[0] = sh[3][5] & ~((|sh[1][3:2]) | (|sh[2][5:4]));
  endfunction : etie

  task automatic check(input byte_t seen, input byte_t exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input int k, input byte_t v);
    mic_host_model_i.write(`DEV_ADDR_DEF, OFS[k], v, ack);
    check({7'h0, ack}, 8'h01);
    sh[k] = v & MSK[k];
  endtask : wr

  task automatic rd(input int k);
    mic_host_model_i.read(`DEV_ADDR_DEF, OFS[k], d, ack);
    check(d, (k == 3) ? (sh[3] | {7'h0, settled}) : sh[k]);
  endtask : rd

  task automatic check_outs();
    repeat (4) @(negedge clk_sys);
    check({3'h0, pd, 2'h0, bias}, {3'h0, sh[0][7], 2'h0, ebias()});
    check({2'h0, lp_r, rp_r, lmp_r}, {2'h0, sh[1][7:2]});
    check({4'h0, cm_r, lmm_r}, {4'h0, sh[2][7:4]});
    check({5'h0, tie}, {5'h0, etie()});
  endtask : check_outs

  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    {det, pres, byp_l, byp_r, settled} = 5'h00;
    lfsr = 16'h0019;
    sh = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    check_outs();
    mic_host_model_i.write(`DEV_ADDR_DEF, `PAGE_CTRL_OFS, `CFG_PAGE, ack);
    for (int k = 0; k < 4; k++) begin
      rd(k);
    end
    mic_host_model_i.read(`DEV_ADDR_DEF, `RSVD_A_OFS, d, ack);
    check(d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        lfsr = lfsr_next(lfsr);
        d = (i == 0) ? 8'hff : lfsr[7:0];
        wr(k, (d & MSK[k]) | ((k == 3) ? 8'h01 : 8'h00));
        {det, pres, byp_l, byp_r, settled} = lfsr[12:8];
        rd(k);
      end
      check_outs();
    end
    mic_host_model_i.write(`DEV_ADDR_DEF ^ 7'h01, `BIAS_OFS, 8'h00, ack);
    check({7'h0, ack}, 8'h00);
    rd(0);
    // other pages take no write to the bank offsets
    mic_host_model_i.write(`DEV_ADDR_DEF, `PAGE_CTRL_OFS, 8'h00, ack);
    mic_host_model_i.write(`DEV_ADDR_DEF, `BIAS_OFS, ~sh[0] & `BIAS_WMASK, ack);
    mic_host_model_i.write(`DEV_ADDR_DEF, `PAGE_CTRL_OFS, `CFG_PAGE, ack);
    rd(0);
    // mid-run reset returns the bank to its reset values
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    sh = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (6) @(negedge clk_sys);
    check_outs();
    mic_host_model_i.write(`DEV_ADDR_DEF, `PAGE_CTRL_OFS, `CFG_PAGE, ack);
    for (int k = 0; k < 4; k++) begin
      rd(k);
    end
    stop_test();
  end
endmodule : test_mic_input_bias_config_regs

`default_nettype wire
